/* File: src/mgmt_pkg.sv */
package mgmt_pkg;

  // ----------------------------------------------------------------
  // mode strap, framing and widths
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_I2C = 2'h2;
  localparam logic [1:0] STRAP_SPI = 2'h3;
  localparam int WORD_BITS = 32;
  localparam int IDX_BITS = 8;
  localparam logic [1:0] DWORD_PAD = 2'h0;
  localparam logic [7:0] INDEX_DEFAULT_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // serial instructions
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_READ_INC = 8'h07;
  localparam logic [7:0] CMD_READ_DECREMENTING = 8'h0B;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_WRITE_INC = 8'h06;
  localparam logic [7:0] CMD_WRITE_DECREMENTING = 8'h0A;

  // ----------------------------------------------------------------
  // bit and byte counts, two-wire slave address
  // ----------------------------------------------------------------
  localparam logic [5:0] SPI_HDR_LAST = 6'h0F;
  localparam logic [5:0] SPI_WORD_LAST = 6'h1F;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [1:0] I2C_LAST_BYTE = 2'h3;
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h0A;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int GLITCH_NS = 100;
  localparam int GLITCH_CYC_RAW = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STEP_FIXED = 2'b00,
    STEP_INC = 2'b01,
    STEP_DEC = 2'b10
  } step_t;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b000,
    SPI_HDR = 3'b001,
    SPI_RD = 3'b010,
    SPI_WR = 3'b011,
    SPI_HALT = 3'b100
  } spi_state_t;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0000,
    I2C_CTRL = 4'b0001,
    I2C_CTRL_ACK = 4'b0010,
    I2C_REGA = 4'b0011,
    I2C_REGA_ACK = 4'b0100,
    I2C_TX = 4'b0101,
    I2C_HACK = 4'b0110,
    I2C_TX_NEXT = 4'b0111,
    I2C_LOAD = 4'b1000,
    I2C_IGNORE = 4'b1001
  } i2c_state_t;

  function automatic logic [7:0] step_index(input logic [7:0] idx, input step_t step,
                                            input logic [7:0] max_idx);
    step_index = idx;
    if (step == STEP_INC) begin
      step_index = (idx == max_idx) ? 8'h00 : idx + 8'h01;
    end else if (step == STEP_DEC) begin
      step_index = (idx == 8'h00) ? max_idx : idx - 8'h01;
    end
  endfunction

endpackage

/* File: src/sync_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sync_if #(parameter int N = 5);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

/* File: src/pin_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_filter #(
  parameter int N = 5,
  parameter int FILT_CYC = mgmt_pkg::GLITCH_CYC,
  parameter logic [N-1:0] IDLE = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, filtered levels out
  sync_if.filt pins
);
  localparam int CW = $clog2(FILT_CYC + 1);

  if (FILT_CYC < 1 || N < 1) begin : g_bad_param
    $error("pin_filter: bad parameters");
  end

  // ----------------------------------------------------------------
  // three-stage sync, then hold-off before accepting a new level
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_bit
    logic [2:0] sh_q;
    logic [CW-1:0] cnt_q;
    logic out_q;
    wire logic agree = (sh_q[1] == sh_q[2]);
    wire logic change = agree && (sh_q[2] != out_q);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sh_q <= {3{IDLE[g]}};
        cnt_q <= '0;
        out_q <= IDLE[g];
      end else begin
        sh_q <= {sh_q[1:0], pins.raw[g]};
        // a pulse that does not stay for the full hold-off is dropped
        if (!change) begin
          cnt_q <= '0;
        end else if (cnt_q == CW'(FILT_CYC - 1)) begin
          out_q <= sh_q[2];
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
    end

    assign pins.clean[g] = out_q;
  end
endmodule
`default_nettype wire

/* File: src/serial_mgmt_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_mgmt_slave #(
  parameter logic [7:0] MAX_INDEX = mgmt_pkg::INDEX_DEFAULT_MAX
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode strap
  input wire logic [1:0] mode_strap,
  // four-wire port
  input wire logic spi_clk,
  input wire logic serial_select_low,
  input wire logic spi_di,
  output logic spi_do,
  output logic spi_do_oe,
  // two-wire port
  input wire logic i2c_clk,
  input wire logic i2c_data_in,
  output logic i2c_data_out,
  output logic i2c_data_oe,
  // register access
  output logic [9:0] reg_rd_addr,
  output logic reg_rd_strobe,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_present,
  output logic [9:0] reg_op_addr,
  output logic reg_rd_done,
  output logic reg_wr,
  output logic [31:0] reg_wdata
);
  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  sync_if #(.N(5)) pins ();
  logic [4:0] prev_q;

  assign pins.raw = {i2c_data_in, i2c_clk, spi_di, serial_select_low, spi_clk};

  pin_filter #(.N(5), .FILT_CYC(mgmt_pkg::GLITCH_CYC), .IDLE(5'h1A)) u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .pins(pins)
  );

  wire logic s_sck = pins.clean[0];
  wire logic s_sel_n = pins.clean[1];
  wire logic s_si = pins.clean[2];
  wire logic s_scl = pins.clean[3];
  wire logic s_sda = pins.clean[4];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 5'h1A;
    end else begin
      prev_q <= pins.clean;
    end
  end

  wire logic sck_rise = s_sck && !prev_q[0];
  wire logic sck_fall = !s_sck && prev_q[0];
  wire logic scl_rise = s_scl && !prev_q[3];
  wire logic scl_fall = !s_scl && prev_q[3];
  wire logic i2c_start = prev_q[4] && !s_sda && s_scl && prev_q[3];
  wire logic i2c_stop = !prev_q[4] && s_sda && s_scl && prev_q[3];

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic mode_vld_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 2'h0;
      mode_vld_q <= 1'b0;
    end else if (!mode_vld_q) begin
      mode_q <= mode_strap;
      mode_vld_q <= 1'b1;
    end
  end

  wire logic spi_en = mode_vld_q && (mode_q == mgmt_pkg::STRAP_SPI);
  wire logic i2c_en = mode_vld_q && (mode_q == mgmt_pkg::STRAP_I2C);
  wire logic [31:0] rdata_m = reg_present ? reg_rdata : 32'h0000_0000;

  // ----------------------------------------------------------------
  // four-wire engine
  // ----------------------------------------------------------------
  mgmt_pkg::spi_state_t spi_st_q;
  mgmt_pkg::step_t spi_step_q;
  logic [5:0] spi_cnt_q;
  logic [31:0] spi_sr_q;
  logic [31:0] spi_out_q;
  logic [7:0] spi_addr_q;
  logic spi_do_q;
  logic spi_oe_q;

  wire logic spi_sel = spi_en && !s_sel_n;
  wire logic [15:0] hdr = {spi_sr_q[14:0], s_si};
  wire logic [7:0] hdr_cmd = hdr[15:8];
  wire logic [7:0] hdr_idx = hdr[7:0];
  wire logic hdr_done = (spi_st_q == mgmt_pkg::SPI_HDR) && sck_rise && (spi_cnt_q == mgmt_pkg::SPI_HDR_LAST);
  wire logic hdr_rd = (hdr_cmd == mgmt_pkg::CMD_READ) || (hdr_cmd == mgmt_pkg::CMD_READ_INC)
                      || (hdr_cmd == mgmt_pkg::CMD_READ_DECREMENTING);
  wire logic hdr_wr = (hdr_cmd == mgmt_pkg::CMD_WRITE) || (hdr_cmd == mgmt_pkg::CMD_WRITE_INC)
                      || (hdr_cmd == mgmt_pkg::CMD_WRITE_DECREMENTING);
  wire mgmt_pkg::step_t hdr_step =
    ((hdr_cmd == mgmt_pkg::CMD_READ_INC) || (hdr_cmd == mgmt_pkg::CMD_WRITE_INC)) ? mgmt_pkg::STEP_INC :
    ((hdr_cmd == mgmt_pkg::CMD_READ_DECREMENTING) || (hdr_cmd == mgmt_pkg::CMD_WRITE_DECREMENTING)) ? mgmt_pkg::STEP_DEC :
    mgmt_pkg::STEP_FIXED;
  wire logic spi_word_done = sck_rise && (spi_cnt_q == mgmt_pkg::SPI_WORD_LAST);
  wire logic [7:0] spi_next_idx = mgmt_pkg::step_index(spi_addr_q, spi_step_q, MAX_INDEX);
  wire logic spi_cap = (hdr_done && hdr_rd) || ((spi_st_q == mgmt_pkg::SPI_RD) && spi_word_done);
  wire logic [7:0] spi_cap_idx = hdr_done ? hdr_idx : spi_next_idx;
  // side effect only after whole word
  wire logic spi_commit = (spi_st_q == mgmt_pkg::SPI_RD) && spi_word_done;
  wire logic spi_wr_ev = (spi_st_q == mgmt_pkg::SPI_WR) && spi_word_done;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_st_q <= mgmt_pkg::SPI_IDLE;
      spi_step_q <= mgmt_pkg::STEP_FIXED;
      spi_cnt_q <= 6'h00;
      spi_addr_q <= 8'h00;
    end else if (!spi_sel) begin
      // select high aborts, partial words dropped
      spi_st_q <= mgmt_pkg::SPI_IDLE;
      spi_cnt_q <= 6'h00;
    end else begin
      case (spi_st_q)
        mgmt_pkg::SPI_IDLE: begin
          spi_st_q <= mgmt_pkg::SPI_HDR;
          spi_cnt_q <= 6'h00;
        end
        mgmt_pkg::SPI_HDR: begin
          if (hdr_done) begin
            spi_cnt_q <= 6'h00;
            spi_addr_q <= hdr_idx;
            spi_step_q <= hdr_step;
            spi_st_q <= hdr_rd ? mgmt_pkg::SPI_RD : (hdr_wr ? mgmt_pkg::SPI_WR : mgmt_pkg::SPI_HALT);
          end else if (sck_rise) begin
            spi_cnt_q <= spi_cnt_q + 6'h01;
          end
        end
        mgmt_pkg::SPI_RD, mgmt_pkg::SPI_WR: begin
          if (spi_word_done) begin
            spi_cnt_q <= 6'h00;
            spi_addr_q <= spi_next_idx;
          end else if (sck_rise) begin
            spi_cnt_q <= spi_cnt_q + 6'h01;
          end
        end
        default: begin
          spi_st_q <= mgmt_pkg::SPI_HALT;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_sr_q <= 32'h0000_0000;
    end else if (spi_sel && sck_rise) begin
      spi_sr_q <= {spi_sr_q[30:0], s_si};
    end
  end

  // shift out on falling edges, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_out_q <= 32'h0000_0000;
      spi_do_q <= 1'b0;
      spi_oe_q <= 1'b0;
    end else if (spi_cap) begin
      spi_out_q <= rdata_m;
    end else if (!spi_sel || (spi_st_q != mgmt_pkg::SPI_RD)) begin
      spi_oe_q <= 1'b0;
    end else if (sck_fall) begin
      spi_do_q <= spi_out_q[31];
      spi_out_q <= {spi_out_q[30:0], 1'b0};
      spi_oe_q <= 1'b1;
    end
  end

  // float as soon as select goes high
  assign spi_do = spi_do_q;
  assign spi_do_oe = spi_oe_q && spi_sel;

  // ----------------------------------------------------------------
  // two-wire engine
  // ----------------------------------------------------------------
  mgmt_pkg::i2c_state_t i_st_q;
  logic [3:0] i_cnt_q;
  logic [1:0] i_byte_q;
  logic [7:0] i_sr_q;
  logic [7:0] i_addr_q;
  logic [31:0] i_word_q;
  logic i_rw_q;
  logic i_multi_q;
  logic i_oe_q;

  wire logic i_nack = s_sda;
  wire logic i_hack = (i_st_q == mgmt_pkg::I2C_HACK) && scl_rise;
  wire logic i_last = (i_byte_q == mgmt_pkg::I2C_LAST_BYTE);
  // wrap to zero past the top
  wire logic [7:0] i_next_idx = mgmt_pkg::step_index(i_addr_q, mgmt_pkg::STEP_INC, MAX_INDEX);
  // capture, then send high byte first
  wire logic i_cap = scl_fall && (((i_st_q == mgmt_pkg::I2C_CTRL_ACK) && i_rw_q) || (i_st_q == mgmt_pkg::I2C_LOAD));
  // commit only after the fourth byte
  wire logic i_commit = i_hack && i_last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i_st_q <= mgmt_pkg::I2C_IDLE;
      i_cnt_q <= 4'h0;
      i_byte_q <= 2'h0;
      i_sr_q <= 8'h00;
      i_addr_q <= 8'h00;
      i_word_q <= 32'h0000_0000;
      i_rw_q <= 1'b0;
      i_multi_q <= 1'b0;
      i_oe_q <= 1'b0;
    end else if (!i2c_en) begin
      i_st_q <= mgmt_pkg::I2C_IDLE;
      i_oe_q <= 1'b0;
    end else if (i2c_start || i2c_stop) begin
      // stray start restarts at the control byte at once, stray stop goes idle
      i_st_q <= i2c_start ? mgmt_pkg::I2C_CTRL : mgmt_pkg::I2C_IDLE;
      i_cnt_q <= 4'h0;
      i_oe_q <= 1'b0;
    end else if (i_cap) begin
      i_word_q <= rdata_m;
      i_oe_q <= !rdata_m[31];
      i_cnt_q <= 4'h0;
      i_st_q <= mgmt_pkg::I2C_TX;
    end else begin
      case (i_st_q)
        mgmt_pkg::I2C_CTRL, mgmt_pkg::I2C_REGA: begin
          if (scl_rise) begin
            i_sr_q <= {i_sr_q[6:0], s_sda};
            i_cnt_q <= i_cnt_q + 4'h1;
          end else if (scl_fall && (i_cnt_q == mgmt_pkg::I2C_BYTE_BITS)) begin
            i_cnt_q <= 4'h0;
            if (i_st_q == mgmt_pkg::I2C_REGA) begin
              // keep the index for later reads
              i_addr_q <= i_sr_q;
              i_oe_q <= 1'b1;
              i_st_q <= mgmt_pkg::I2C_REGA_ACK;
            end else if (i_sr_q[7:1] == mgmt_pkg::I2C_SLAVE_ADDR) begin
              i_rw_q <= i_sr_q[0];
              i_multi_q <= 1'b0;
              i_byte_q <= 2'h0;
              i_oe_q <= 1'b1;
              i_st_q <= mgmt_pkg::I2C_CTRL_ACK;
            end else begin
              i_st_q <= mgmt_pkg::I2C_IGNORE;
            end
          end
        end
        mgmt_pkg::I2C_CTRL_ACK: begin
          if (scl_fall) begin
            i_oe_q <= 1'b0;
            i_st_q <= mgmt_pkg::I2C_REGA;
          end
        end
        mgmt_pkg::I2C_REGA_ACK: begin
          // data bytes of a write are not handled here
          if (scl_fall) begin
            i_oe_q <= 1'b0;
            i_st_q <= mgmt_pkg::I2C_IGNORE;
          end
        end
        mgmt_pkg::I2C_TX: begin
          if (scl_rise) begin
            i_cnt_q <= i_cnt_q + 4'h1;
          end else if (scl_fall && (i_cnt_q == mgmt_pkg::I2C_BYTE_BITS)) begin
            i_oe_q <= 1'b0;
            i_st_q <= mgmt_pkg::I2C_HACK;
          end else if (scl_fall) begin
            i_oe_q <= !i_word_q[30];
            i_word_q <= {i_word_q[30:0], 1'b0};
          end
        end
        mgmt_pkg::I2C_HACK: begin
          // address moves only in a multi-read
          if (i_hack && i_last) begin
            i_byte_q <= 2'h0;
            if (!i_nack || i_multi_q) begin
              i_addr_q <= i_next_idx;
            end
            i_multi_q <= i_multi_q || !i_nack;
            i_st_q <= i_nack ? mgmt_pkg::I2C_IGNORE : mgmt_pkg::I2C_LOAD;
          end else if (i_hack) begin
            i_byte_q <= i_byte_q + 2'h1;
            i_st_q <= i_nack ? mgmt_pkg::I2C_IGNORE : mgmt_pkg::I2C_TX_NEXT;
          end
        end
        mgmt_pkg::I2C_TX_NEXT: begin
          if (scl_fall) begin
            i_oe_q <= !i_word_q[30];
            i_word_q <= {i_word_q[30:0], 1'b0};
            i_cnt_q <= 4'h0;
            i_st_q <= mgmt_pkg::I2C_TX;
          end
        end
        default: begin
          i_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign i2c_data_out = 1'b0;
  assign i2c_data_oe = i_oe_q;

  // ----------------------------------------------------------------
  // register access port
  // ----------------------------------------------------------------
  logic rd_done_q;
  logic wr_q;
  logic [9:0] op_addr_q;
  logic [31:0] wdata_q;

  assign reg_rd_addr = {(spi_en ? spi_cap_idx : i_addr_q), mgmt_pkg::DWORD_PAD};
  assign reg_rd_strobe = spi_cap || i_cap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_done_q <= 1'b0;
      wr_q <= 1'b0;
      op_addr_q <= 10'h000;
      wdata_q <= 32'h0000_0000;
    end else begin
      rd_done_q <= spi_commit || i_commit;
      wr_q <= spi_wr_ev;
      if (spi_commit || spi_wr_ev || i_commit) begin
        op_addr_q <= {(spi_en ? spi_addr_q : i_addr_q), mgmt_pkg::DWORD_PAD};
      end
      if (spi_wr_ev) begin
        wdata_q <= {spi_sr_q[30:0], s_si};
      end
    end
  end

  assign reg_op_addr = op_addr_q;
  assign reg_rd_done = rd_done_q;
  assign reg_wr = wr_q;
  assign reg_wdata = wdata_q;
endmodule
`default_nettype wire

/* File: verification/serial_mgmt_slave_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_mgmt_slave_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // strap and pins
  input wire logic [1:0] mode_strap,
  input wire logic serial_select_low,
  input wire logic spi_do_oe,
  input wire logic i2c_data_oe,
  // register side
  input wire logic [9:0] reg_rd_addr,
  input wire logic reg_rd_strobe,
  input wire logic [9:0] reg_op_addr,
  input wire logic reg_rd_done,
  input wire logic reg_wr
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a word takes 32 link bits, so pulses never come close together
  sequence quiet8(sig);
    !sig [*8];
  endsequence
  strobe_addr_pad_a: assert property (reg_rd_strobe |-> reg_rd_addr[1:0] == mgmt_pkg::DWORD_PAD)
    else $error("capture address not dword aligned");
  op_addr_pad_a: assert property ((reg_wr || reg_rd_done) |-> reg_op_addr[1:0] == mgmt_pkg::DWORD_PAD)
    else $error("commit address not dword aligned");
  write_pulse_a: assert property (reg_wr |=> quiet8(reg_wr))
    else $error("write pulse repeated");
  done_pulse_a: assert property (reg_rd_done |=> quiet8(reg_rd_done))
    else $error("read done pulse repeated");
  latch_once_a: assert property (reg_rd_strobe |=> quiet8(reg_rd_strobe))
    else $error("capture repeated within a word");
  spi_done_order_a: assert property ((mode_strap == mgmt_pkg::STRAP_SPI && reg_rd_done) |-> $past(reg_rd_strobe))
    else $error("read done without next capture");
  spi_float_a: assert property (serial_select_low [*8] |-> !spi_do_oe)
    else $error("output driven while deselected");
  spi_write_quiet_a: assert property (reg_wr |-> !spi_do_oe)
    else $error("output driven during write");
  i2c_gate_a: assert property (mode_strap != mgmt_pkg::STRAP_I2C |-> !i2c_data_oe)
    else $error("two-wire port active in wrong mode");
  spi_gate_a: assert property (mode_strap != mgmt_pkg::STRAP_SPI |-> !spi_do_oe)
    else $error("four-wire port active in wrong mode");
endmodule
bind serial_mgmt_slave serial_mgmt_slave_checker serial_mgmt_slave_checker_inst (.clk, .rst_n, .mode_strap,
  .serial_select_low, .spi_do_oe, .i2c_data_oe, .reg_rd_addr, .reg_rd_strobe, .reg_op_addr, .reg_rd_done, .reg_wr);
`default_nettype wire

/* File: verification/mgmt_host.sv */
`timescale 1ns/1ns
`default_nettype none
module mgmt_host (
  // clock
  input wire logic clk,
  // four-wire side
  output logic spi_clk,
  output logic serial_select_low,
  output logic spi_di,
  input wire logic spi_do,
  input wire logic spi_do_oe,
  // two-wire side
  output logic i2c_clk,
  output logic sda,
  input wire logic i2c_data_out,
  input wire logic i2c_data_oe
);
  logic pull = 1'b0;
  // pulled-up wire: low if either side pulls
  assign sda = !(pull || (i2c_data_oe && !i2c_data_out));
  initial begin
    spi_clk = 1'b0;
    serial_select_low = 1'b1;
    spi_di = 1'b0;
    i2c_clk = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic spi(input logic [7:0] cmd, idx, input int nb, input logic [63:0] wd,
                     output logic [95:0] rd, output logic oe);
    logic [95:0] sh;
    sh = {cmd, idx, wd, 16'hA5C3};
    rd = '0;
    oe = 1'b0;
    serial_select_low = 1'b0;
    w(4);
    for (int i = 0; i < 16 + nb; i++) begin
      spi_di = sh[95 - i];
      w(4);
      spi_clk = 1'b1;
      w(4);
      // sampled late in the high phase: the pin path is several clocks deep
      // a released line reads back as the inverse of what was last driven
      rd = {rd[94:0], spi_do_oe ? spi_do : !spi_do};
      oe = oe | spi_do_oe;
      spi_clk = 1'b0;
    end
    w(4);
    serial_select_low = 1'b1;
    spi_di = !spi_di;
    // select must stay high long enough to pass the pin filter before the next frame
    w(8);
  endtask
  task automatic i2c_bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      w(2);
      pull = !tx[i];
      w(4);
      i2c_clk = 1'b1;
      w(4);
      rx[i] = sda;
      i2c_clk = 1'b0;
    end
  endtask
  task automatic i2c_start;
    w(2);
    pull = 1'b0;
    w(4);
    i2c_clk = 1'b1;
    w(4);
    pull = 1'b1;
    w(4);
    i2c_clk = 1'b0;
  endtask
  task automatic i2c_stop;
    w(2);
    pull = 1'b1;
    w(4);
    i2c_clk = 1'b1;
    w(4);
    pull = 1'b0;
    w(4);
  endtask
endmodule
`default_nettype wire

/* File: verification/serial_mgmt_slave_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_mgmt_slave_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] mode_strap = mgmt_pkg::STRAP_SPI;
  logic spi_clk, serial_select_low, spi_di, spi_do, spi_do_oe;
  logic i2c_clk, sda, i2c_data_out, i2c_data_oe;
  logic [9:0] reg_rd_addr, reg_op_addr;
  logic reg_rd_strobe, reg_present, reg_rd_done, reg_wr;
  logic [31:0] reg_rdata, reg_wdata;
  logic [31:0] mem [8];
  logic [31:0] snap [8];
  logic [42:0] q [$];
  logic [42:0] eq [$];
  logic [7:0] cmds [6] = '{8'h03, 8'h07, 8'h0B, 8'h02, 8'h06, 8'h0A};
  // write indices avoid the absent index 6
  logic [7:0] idxs [6] = '{8'h02, 8'h07, 8'h00, 8'h02, 8'h07, 8'h00};
  logic [95:0] rd;
  logic [8:0] rx;
  logic [31:0] wd0, wd1;
  logic [7:0] i0, i1;
  logic oe, wr;
  int bad_count = 0;
  int n_tests = 0;
  always #50 clk = !clk;
  serial_mgmt_slave #(.MAX_INDEX(8'h07)) serial_mgmt_slave_inst (.clk(clk), .rst_n(rst_n),
    .mode_strap(mode_strap), .spi_clk(spi_clk), .serial_select_low(serial_select_low), .spi_di(spi_di),
    .spi_do(spi_do), .spi_do_oe(spi_do_oe), .i2c_clk(i2c_clk), .i2c_data_in(sda), .i2c_data_out(i2c_data_out),
    .i2c_data_oe(i2c_data_oe), .reg_rd_addr(reg_rd_addr), .reg_rd_strobe(reg_rd_strobe), .reg_rdata(reg_rdata),
    .reg_present(reg_present), .reg_op_addr(reg_op_addr), .reg_rd_done(reg_rd_done), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  mgmt_host mgmt_host_inst (.clk(clk), .spi_clk(spi_clk), .serial_select_low(serial_select_low),
    .spi_di(spi_di), .spi_do(spi_do), .spi_do_oe(spi_do_oe), .i2c_clk(i2c_clk), .sda(sda),
    .i2c_data_out(i2c_data_out), .i2c_data_oe(i2c_data_oe));
  // ----
  // register model: index 6 absent, each capture bumps the register
  // ----
  assign reg_present = reg_rd_addr[9:2] != 8'h06;
  assign reg_rdata = mem[reg_rd_addr[4:2]];
  always @(posedge clk) begin
    if (reg_rd_strobe && reg_present) begin
      mem[reg_rd_addr[4:2]] <= mem[reg_rd_addr[4:2]] + 32'h1;
    end
    if (reg_wr) begin
      mem[reg_op_addr[4:2]] <= reg_wdata;
      q.push_back({1'b1, reg_op_addr, reg_wdata});
    end
    if (reg_rd_done) begin
      q.push_back({1'b0, reg_op_addr, 32'h0});
    end
  end
  function automatic logic [7:0] nxt(input logic [7:0] i, input logic [7:0] cmd);
    case (cmd[3:2])
      2'h1: nxt = (i == 8'h07) ? 8'h00 : i + 8'h01;
      2'h2: nxt = (i == 8'h00) ? 8'h07 : i - 8'h01;
      default: nxt = i;
    endcase
  endfunction
  function automatic logic [31:0] rdv(input logic [7:0] i, input int bump);
    rdv = (i == 8'h06) ? 32'h0 : snap[i[2:0]] + bump;
  endfunction
  task automatic chk(input logic [63:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic drain;
    chk(q.size(), eq.size());
    while (eq.size() > 0 && q.size() > 0) chk(q.pop_front(), eq.pop_front());
    q.delete();
    eq.delete();
  endtask
  task automatic restart(input logic [1:0] s);
    rst_n = 1'b0;
    mode_strap = s;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // no access until the pin path has settled
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic i2c_read(input logic [7:0] i, input int n);
    logic [31:0] w;
    snap = mem;
    mgmt_host_inst.i2c_start();
    mgmt_host_inst.i2c_bits({8'h15, 1'b1}, rx);
    chk(rx[0], 1'b0);
    for (int k = 0; k < n; k++) begin
      for (int b = 0; b < 4; b++) begin
        mgmt_host_inst.i2c_bits({8'hFF, ((k == n - 1) && (b == 3))}, rx);
        w = {w[23:0], rx[8:1]};
      end
      chk(w, rdv(i, 0));
      eq.push_back({1'b0, i, 2'h0, 32'h0});
      i = nxt(i, 8'h07);
    end
    mgmt_host_inst.i2c_stop();
    drain();
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(83));
    foreach (mem[i]) mem[i] = $urandom;
    restart(mgmt_pkg::STRAP_SPI);
    // two full words then a partial third, for all six instructions
    for (int k = 0; k < 6; k++) begin
      snap = mem;
      i0 = idxs[k];
      i1 = nxt(i0, cmds[k]);
      wd0 = $urandom;
      wd1 = $urandom;
      wr = k > 2;
      eq.push_back({wr, i0, 2'h0, wr ? wd0 : 32'h0});
      eq.push_back({wr, i1, 2'h0, wr ? wd1 : 32'h0});
      mgmt_host_inst.spi(cmds[k], i0, 80, {wd0, wd1}, rd, oe);
      if (wr) begin
        chk(oe, 1'b0);
      end else begin
        chk(rd[79:16], {rdv(i0, 0), rdv(i1, k == 0)});
      end
      drain();
    end
    // an unknown instruction must leave the port silent and commit nothing
    mgmt_host_inst.spi(8'h01, i0, 40, {wd0, wd1}, rd, oe);
    chk(oe, 1'b0);
    drain();
    restart(mgmt_pkg::STRAP_I2C);
    mgmt_host_inst.i2c_start();
    mgmt_host_inst.i2c_bits({8'h14, 1'b1}, rx);
    chk(rx[0], 1'b0);
    mgmt_host_inst.i2c_bits({8'h05, 1'b1}, rx);
    chk(rx[0], 1'b0);
    mgmt_host_inst.i2c_stop();
    i2c_read(8'h05, 2);
    i2c_read(8'h07, 1);
    i2c_read(8'h07, 2);
    mgmt_host_inst.i2c_start();
    mgmt_host_inst.i2c_bits({8'h16, 1'b1}, rx);
    chk(rx[0], 1'b1);
    mgmt_host_inst.i2c_bits({8'hFF, 1'b1}, rx);
    chk(rx, 9'h1FF);
    mgmt_host_inst.i2c_stop();
    snap = mem;
    mgmt_host_inst.i2c_start();
    mgmt_host_inst.i2c_bits({8'h15, 1'b1}, rx);
    mgmt_host_inst.i2c_bits({8'hFF, 1'b1}, rx);
    chk(rx[8:1], snap[1][31:24]);
    mgmt_host_inst.i2c_bits({8'hFF, 1'b1}, rx);
    chk(rx, 9'h1FF);
    mgmt_host_inst.i2c_stop();
    drain();
    tally_and_finish();
  end
endmodule
`default_nettype wire
